// ===== card_panel_pkg.sv
// Purpose: Shared constants for the card reader status word and operator panel logic.
// Assumes: One system clock; host command word presented with a one-cycle read strobe.
// Notes:   Status bit positions, command field positions and reset values live here.
package card_panel_pkg;

    localparam int STATUS_W = 16;
    localparam int CMD_W    = 16;
    localparam int EQUIP_W  = 4;
    localparam int AMP_W    = 12;

    // Command word fields.
    localparam int CMD_DIR_LO    = 0;
    localparam int CMD_DIR_HI    = 1;
    localparam int CMD_EQUIP_LO  = 7;
    localparam int CMD_EQUIP_HI  = 10;
    localparam int CMD_ROUTE_LO  = 11;
    localparam int CMD_ROUTE_HI  = 15;
    localparam logic [1:0] DIR_LEVEL2 = 2'h3;

    // Transport fault status word bit positions.
    localparam int ST_HOPPER_EMPTY = 0;
    localparam int ST_STACKER_FULL = 1;
    localparam int ST_FAIL_TO_FEED = 2;
    localparam int ST_READ_JAM     = 3;
    localparam int ST_POST_JAM     = 4;
    localparam int ST_STACKER_JAM  = 5;
    localparam int ST_PREREAD_ERR  = 6;
    localparam int ST_MANUAL       = 8;
    localparam int ST_INTERLOCK    = 10;

    localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0000;
    localparam logic [STATUS_W-1:0] STATUS_USED  = 16'h057f;

    typedef enum logic [1:0] {
        RDY_IDLE     = 2'b00,
        RDY_READY    = 2'b01,
        RDY_STOPPING = 2'b10
    } ready_e;

endpackage : card_panel_pkg

// ===== panel_press_if.sv
// Purpose: Carries debounced panel button levels and their press/release pulses.
// Assumes: Button levels are synchronous to the clock.
// Notes:   Bit order: 0 ready, 1 single cycle, 2 deck_tail_hold_button hold, 3 protect.
`timescale 1ns/1ps
interface panel_press_if #(parameter int N = 4);
    logic [N-1:0] level;
    logic [N-1:0] press;
    logic [N-1:0] release_p;

    modport detector (input level, output press, output release_p);
    modport user     (output level, input press, input release_p);
endinterface : panel_press_if

// ===== panel_press_detect.sv
// Purpose: Turns panel button levels into one-cycle press and release pulses.
// Assumes: Levels are clean and synchronous.
// Notes:   One flop per button holds the previous level.
`timescale 1ns/1ps
module panel_press_detect #(
    parameter int N = 4
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    panel_press_if.detector  btn
);
    import card_panel_pkg::*;

    typedef struct packed {
        logic [N-1:0] prev;
    } state_s;

    state_s state_q;
    state_s state_d;

    always_comb begin
        state_d.prev = btn.level;
    end

    for (genvar i = 0; i < N; i++) begin : g_edge
        assign btn.press[i]     = btn.level[i] & ~state_q.prev[i];
        assign btn.release_p[i] = ~btn.level[i] & state_q.prev[i];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : panel_press_detect

// ===== card_reader_fault_status_panel.sv
// Purpose: Level-2 transport fault status word and operator/maintenance panel control.
// Assumes: Sensor, switch and host signals are synchronous to clock.
// Notes:   An addressed host read is answered one cycle after its strobe with reply or reject.
//
// Overview of operation
// - Read with both low command bits set returns the status word on sixteen lines.
// - Respond only when command equipment bits equal the equipment select switches.
// - Status bit zero is one while the input hopper is empty.
// - Status bit one is one while the stacker sensor reports full.
// - Bit two sets when feed completes, ready station empty, hopper has cards.
// - Jams report on bit three read area, four post read, five stacker.
// - Bit six sets when the pre-read check finds an amplifier failure.
// - Bit eight is one while the free-run maintenance switch is on.
// - Bit ten is one while the door interlock is de-energized.
// - Bits seven, nine and eleven to fifteen carry no status.
// - Ready press feeds a card if station empty and no not-ready cause.
// - Ready press clears fail-to-feed and pre-read alert indications.
// - Ready press and release while ready ends after current operation, then not-ready.
// - Single-cycle press runs one card cycle only while not ready.
// - Deck_tail_hold_button button toggles hold; set lights lamp and raises status.
// - With deck_tail_hold_button set, stay ready after the hopper empties.
// - Transport fault lamp latches on feed failure or jam; ready or single-cycle clears.
// - Pre-read: amplifiers all on when uncovered, all off when covered; else alert.
// - Lid-open lamp lights while the top lid interlock reports open.
// - Protect press toggles protection; protected accepts only protect-line commands.
// - Free-run detaches host and feeds at full rate while ready; ready starts/stops.
// - Reset-inhibit switch disables automatic reset only while free-run is on.
`timescale 1ns/1ps
module card_reader_fault_status_panel #(
    parameter int AMP_N = card_panel_pkg::AMP_W
) (
    input  wire logic                                 clock,
    input  wire logic                                 sys_rst,
    input  wire logic                                 master_clear,
    input  wire logic                                 host_read,
    input  wire logic [card_panel_pkg::CMD_W-1:0]     host_cmd,
    input  wire logic                                 host_protect,
    input  wire logic [card_panel_pkg::EQUIP_W-1:0]   equip_select_sw,
    output logic [card_panel_pkg::STATUS_W-1:0]       host_data,
    output logic                                      host_data_oe,
    output logic                                      host_reply,
    output logic                                      host_reject,
    input  wire logic                                 power_ok,
    input  wire logic                                 hopper_empty,
    input  wire logic                                 stacker_full,
    input  wire logic                                 ready_station_card,
    input  wire logic                                 feed_cycle_done,
    input  wire logic                                 card_busy,
    input  wire logic                                 read_area_jam,
    input  wire logic                                 post_read_jam,
    input  wire logic                                 stacker_area_jam,
    input  wire logic                                 preread_light_check,
    input  wire logic                                 preread_dark_check,
    input  wire logic [AMP_N-1:0]                     amp_on,
    input  wire logic                                 door_interlock_energized,
    input  wire logic                                 top_lid_open,
    input  wire logic                                 ready_button,
    input  wire logic                                 single_cycle_button,
    input  wire logic                                 deck_tail_hold_button,
    input  wire logic                                 protect_button,
    input  wire logic                                 free_run_sw,
    input  wire logic                                 reset_inhibit_sw,
    output logic                                      feed_card,
    output logic                                      host_ops_enable,
    output logic                                      auto_reset_enable,
    output logic                                      ready_lamp,
    output logic                                      feed_alert_lamp,
    output logic                                      read_alert_lamp,
    output logic                                      lid_open_lamp,
    output logic                                      deck_tail_lamp,
    output logic                                      deck_tail_status,
    output logic                                      protect_lamp,
    output logic                                      host_detached
);
    import card_panel_pkg::*;

    localparam int B_READY  = 0;
    localparam int B_SINGLE = 1;
    localparam int B_EOF    = 2;
    localparam int B_PROT   = 3;

    typedef struct packed {
        ready_e                rdy;
        logic                  fail_to_feed;
        logic                  jam_read;
        logic                  jam_post;
        logic                  jam_stacker;
        logic                  preread_err;
        logic                  feed_alert;
        logic                  eof_hold;
        logic                  protect;
        logic                  stop_armed;
        logic                  feed;
        logic                  reply;
        logic                  reject;
        logic                  data_oe;
        logic [STATUS_W-1:0]   data;
    } state_s;

    state_s state_q;
    state_s state_d;

    panel_press_if #(.N(4)) btn ();

    assign btn.level = {protect_button, deck_tail_hold_button,
                        single_cycle_button, ready_button};

    panel_press_detect #(
        .N (4)
    ) u_press (
        .clock   (clock),
        .sys_rst (sys_rst),
        .btn     (btn)
    );

    logic                is_ready;
    logic                not_ready_cause;
    logic                any_jam;
    logic                preread_bad;
    logic                clear_alerts;
    logic                clear_feed_alert;
    logic                addressed;
    logic                accepted;
    logic [STATUS_W-1:0] status_word;

    always_comb begin
        is_ready = (state_q.rdy != RDY_IDLE);
        any_jam  = read_area_jam | post_read_jam | stacker_area_jam;
        // Hopper empty only blocks ready when the deck_tail_hold_button hold is off.
        not_ready_cause = ~power_ok | stacker_full | any_jam | top_lid_open
                        | (hopper_empty & ~state_q.eof_hold);
        preread_bad = (preread_light_check & ~(&amp_on))
                    | (preread_dark_check & (|amp_on));
        clear_alerts     = btn.press[B_READY] | master_clear;
        clear_feed_alert = btn.press[B_READY] | btn.press[B_SINGLE] | master_clear;
        addressed = (host_cmd[CMD_EQUIP_HI:CMD_EQUIP_LO] == equip_select_sw)
                  & (host_cmd[CMD_ROUTE_HI:CMD_ROUTE_LO] == '0);
        accepted  = host_read & addressed & (~state_q.protect | host_protect)
                  & (host_cmd[CMD_DIR_HI:CMD_DIR_LO] == DIR_LEVEL2);
    end

    // Status word assembled from live sensors and latched conditions.
    always_comb begin
        status_word                  = STATUS_RESET;
        status_word[ST_HOPPER_EMPTY] = hopper_empty;
        status_word[ST_STACKER_FULL] = stacker_full;
        status_word[ST_FAIL_TO_FEED] = state_q.fail_to_feed;
        status_word[ST_READ_JAM]     = state_q.jam_read;
        status_word[ST_POST_JAM]     = state_q.jam_post;
        status_word[ST_STACKER_JAM]  = state_q.jam_stacker;
        status_word[ST_PREREAD_ERR]  = state_q.preread_err;
        status_word[ST_MANUAL]       = free_run_sw;
        status_word[ST_INTERLOCK]    = ~door_interlock_energized;
        status_word                  = status_word & STATUS_USED;
    end

    always_comb begin
        state_d = state_q;

        // Sticky conditions: a new event in the clearing cycle wins.
        state_d.fail_to_feed = (state_q.fail_to_feed & ~clear_alerts)
                             | (feed_cycle_done & ~ready_station_card & ~hopper_empty);
        state_d.preread_err  = (state_q.preread_err & ~clear_alerts) | preread_bad;
        state_d.jam_read     = (state_q.jam_read & ~clear_feed_alert) | read_area_jam;
        state_d.jam_post     = (state_q.jam_post & ~clear_feed_alert) | post_read_jam;
        state_d.jam_stacker  = (state_q.jam_stacker & ~clear_feed_alert) | stacker_area_jam;
        state_d.feed_alert   = (state_q.feed_alert & ~clear_feed_alert) | any_jam
                             | (feed_cycle_done & ~ready_station_card & ~hopper_empty);

        if (btn.press[B_EOF]) begin
            state_d.eof_hold = ~state_q.eof_hold;
        end
        if (btn.press[B_PROT]) begin
            state_d.protect = ~state_q.protect;
        end

        state_d.feed       = 1'b0;
        state_d.stop_armed = 1'b0;
        unique case (state_q.rdy)
            RDY_IDLE: begin
                if (btn.press[B_READY] && !not_ready_cause) begin
                    state_d.rdy  = RDY_READY;
                    state_d.feed = ~ready_station_card;
                end else if (btn.press[B_SINGLE]) begin
                    state_d.feed = 1'b1;
                end
            end
            RDY_READY: begin
                // Only a press made while ready arms the stop, so releasing the press
                // that made the reader ready does not take it straight out again.
                state_d.stop_armed = btn.press[B_READY]
                                   | (state_q.stop_armed & btn.level[B_READY]);
                if (not_ready_cause) begin
                    state_d.rdy = RDY_IDLE;
                end else if (btn.release_p[B_READY] && state_q.stop_armed) begin
                    state_d.rdy = RDY_STOPPING;
                end else if (free_run_sw && !card_busy && !state_q.feed) begin
                    state_d.feed = 1'b1;
                end
            end
            RDY_STOPPING: begin
                if (!card_busy || not_ready_cause) begin
                    state_d.rdy = RDY_IDLE;
                end
            end
            default: begin
                state_d.rdy = RDY_IDLE;
            end
        endcase

        if (master_clear) begin
            state_d.eof_hold = 1'b0;
        end

        // Host answer: data and strobe registered one cycle after the read.
        state_d.reply   = accepted;
        state_d.reject  = host_read & addressed & ~accepted;
        state_d.data_oe = accepted;
        state_d.data    = accepted ? status_word : STATUS_RESET;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q     <= '0;
            state_q.rdy <= RDY_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign host_data         = state_q.data;
    assign host_data_oe      = state_q.data_oe;
    assign host_reply        = state_q.reply;
    assign host_reject       = state_q.reject;
    assign feed_card         = state_q.feed;
    assign ready_lamp        = is_ready;
    assign host_detached     = free_run_sw & is_ready;
    assign host_ops_enable   = (state_q.rdy == RDY_READY) & ~free_run_sw;
    assign auto_reset_enable = ~(reset_inhibit_sw & free_run_sw);
    assign feed_alert_lamp   = state_q.feed_alert;
    assign read_alert_lamp   = state_q.preread_err;
    assign lid_open_lamp     = top_lid_open;
    assign deck_tail_lamp    = state_q.eof_hold;
    assign deck_tail_status  = state_q.eof_hold;
    assign protect_lamp      = state_q.protect;

endmodule : card_reader_fault_status_panel

// ===== card_panel_properties.sv
// Purpose: Concurrent checks on the host status read and the panel ports.
// Assumes: All ports are synchronous to clock; sys_rst is synchronous, active high.
// Notes:   Bound to every instance of the panel block.
`timescale 1ns/1ps
module card_panel_properties (
    input wire logic                                 clock,
    input wire logic                                 sys_rst,
    input wire logic                                 host_read,
    input wire logic [card_panel_pkg::CMD_W-1:0]     host_cmd,
    input wire logic                                 host_protect,
    input wire logic [card_panel_pkg::EQUIP_W-1:0]   equip_select_sw,
    input wire logic [card_panel_pkg::STATUS_W-1:0]  host_data,
    input wire logic                                 host_data_oe,
    input wire logic                                 host_reply,
    input wire logic                                 host_reject,
    input wire logic                                 hopper_empty,
    input wire logic                                 stacker_full,
    input wire logic                                 top_lid_open,
    input wire logic                                 ready_button,
    input wire logic                                 single_cycle_button,
    input wire logic                                 free_run_sw,
    input wire logic                                 host_ops_enable,
    input wire logic                                 ready_lamp,
    input wire logic                                 lid_open_lamp,
    input wire logic                                 protect_lamp,
    input wire logic                                 feed_card
);
    import card_panel_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    wire addressed = host_read && host_cmd[10:7] == equip_select_sw && host_cmd[15:11] == 5'h00;

    sequence s_single_press;
        !single_cycle_button ##1 (single_cycle_button && !ready_lamp);
    endsequence
    sequence s_ready_release;
        (!ready_button && host_ops_enable) ##1 (ready_button && host_ops_enable) ##1 !ready_button;
    endsequence

    a_reply_status: assert property (addressed && host_cmd[1:0] == DIR_LEVEL2 &&
        (!protect_lamp || host_protect) |=> host_reply && host_data_oe && !host_reject)
        else $error("accepted read got no status reply");
    a_unaddr_silent: assert property (host_read && !addressed |=>
        !host_reply && !host_reject && !host_data_oe) else $error("foreign command answered");
    a_live_bits: assert property (host_reply |-> host_data[0] == $past(hopper_empty) &&
        host_data[1] == $past(stacker_full) && host_data[8] == $past(free_run_sw))
        else $error("live status bits wrong");
    a_unused_zero: assert property (host_data_oe |->
        (host_data & ~STATUS_USED) == 16'h0000) else $error("unused status bit set");
    a_protect_reject: assert property (addressed && protect_lamp && !host_protect |=>
        host_reject && !host_reply) else $error("unprotected read served while protected");
    a_lid_lamp: assert property (lid_open_lamp == top_lid_open)
        else $error("lid lamp does not follow lid");
    a_single_feed: assert property (s_single_press |=> feed_card)
        else $error("single cycle press gave no feed");
    a_stop_release: assert property (s_ready_release |=> !host_ops_enable)
        else $error("host operations still enabled after stop");
endmodule : card_panel_properties

bind card_reader_fault_status_panel card_panel_properties chk_u (.*);

// ===== host_channel_model.sv
// Purpose: Host data channel that issues status reads to the panel block.
// Assumes: Inputs change on the falling edge; the answer comes one cycle after the read.
// Notes:   Released command lines show the inverse of the last value.
`timescale 1ns/1ps
module host_channel_model (
    input  wire logic                                 clock,
    output logic                                      host_read,
    output logic [card_panel_pkg::CMD_W-1:0]          host_cmd,
    output logic                                      host_protect,
    input  wire logic [card_panel_pkg::STATUS_W-1:0]  host_data,
    input  wire logic                                 host_data_oe,
    input  wire logic                                 host_reply,
    input  wire logic                                 host_reject
);
    import card_panel_pkg::*;
    initial begin
        host_read = 1'b0;
        host_cmd = 16'h0000;
        host_protect = 1'b0;
    end
    task automatic issue_read(input logic [15:0] cmd, input logic prot, output logic [18:0] ans);
        @(negedge clock);
        host_read = 1'b1;
        host_cmd = cmd;
        host_protect = prot;
        @(negedge clock);
        ans = {host_reply, host_reject, host_data_oe, host_data};
        host_read = 1'b0;
        host_cmd = ~cmd;
        host_protect = ~prot;
    endtask : issue_read
endmodule : host_channel_model

// ===== tb.sv
// Purpose: Self-checking bench for the status word and operator panel block.
// Assumes: Inputs change on the falling edge of a 250 MHz clock.
// Notes:   Host reads go through the host channel model.
`timescale 1ns/1ps
module tb;
    import card_panel_pkg::*;
    logic clock = 1'b0, sys_rst, master_clear, host_read, host_protect, power_ok, hopper_empty;
    logic stacker_full, ready_station_card, feed_cycle_done, card_busy, read_area_jam;
    logic post_read_jam, stacker_area_jam, preread_light_check, preread_dark_check;
    logic door_interlock_energized, top_lid_open, free_run_sw, reset_inhibit_sw;
    logic host_data_oe, host_reply, host_reject, feed_card, host_ops_enable, auto_reset_enable;
    logic ready_lamp, feed_alert_lamp, read_alert_lamp, lid_open_lamp, deck_tail_lamp;
    logic deck_tail_status, protect_lamp, host_detached;
    logic [CMD_W-1:0]    host_cmd;
    logic [STATUS_W-1:0] host_data;
    logic [EQUIP_W-1:0]  equip_select_sw;
    logic [AMP_W-1:0]    amp_on;
    logic [18:0]         ans;
    logic [6:2]          sticky;
    logic [3:0]          btn;
    int                  err_count = 0, num_checks = 0, cyc = 0, n;
    wire ready_button = btn[0], single_cycle_button = btn[1];
    wire deck_tail_hold_button = btn[2], protect_button = btn[3];

    card_reader_fault_status_panel dut_u (.*);
    host_channel_model host_u (.*);

    always #2 clock = ~clock;

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [15:0] exp_st();
        return {5'h00, ~door_interlock_energized, 1'b0, free_run_sw, 1'b0, sticky,
                stacker_full, hopper_empty};
    endfunction : exp_st

    function automatic logic [15:0] cmd(input logic [1:0] dir);
        return {5'h00, equip_select_sw, 5'h00, dir};
    endfunction : cmd

    task automatic rd(input logic [15:0] c, input logic prot, input logic [2:0] e, input logic [15:0] d);
        host_u.issue_read(c, prot, ans);
        check("reply reject oe", {13'h0, e}, {13'h0, ans[18:16]});
        check("status word", d, ans[15:0]);
    endtask : rd

    task automatic push(input int i);
        @(negedge clock);
        btn[i] = 1'b1;
        @(negedge clock);
        btn[i] = 1'b0;
    endtask : push

    task automatic strobe(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask : strobe

    initial begin
        {master_clear, hopper_empty, stacker_full, feed_cycle_done, card_busy} = '0;
        {read_area_jam, post_read_jam, stacker_area_jam, preread_light_check} = '0;
        {preread_dark_check, top_lid_open, free_run_sw, btn, sticky, amp_on} = '0;
        {power_ok, door_interlock_energized, ready_station_card, sys_rst} = 4'hf;
        equip_select_sw = 4'h5;
        reset_inhibit_sw = 1'b1;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        check("reset lamps", 16'h0000, {13'h0, ready_lamp, protect_lamp, deck_tail_lamp});
        for (int i = 0; i < 4; i++) begin
            {hopper_empty, stacker_full, free_run_sw, door_interlock_energized} = 4'h1 ^ (4'h8 >> i);
            top_lid_open = i[0];
            rd(cmd(DIR_LEVEL2), 1'b0, 3'h5, exp_st());
            check("auto reset", {15'h0, ~free_run_sw}, {15'h0, auto_reset_enable});
            check("lid lamp", {15'h0, top_lid_open}, {15'h0, lid_open_lamp});
        end
        {hopper_empty, stacker_full, free_run_sw, door_interlock_energized, top_lid_open} = 5'h02;
        rd(cmd(DIR_LEVEL2) ^ 16'h0080, 1'b0, 3'h0, 16'h0000);
        rd(cmd(DIR_LEVEL2) | 16'h0800, 1'b0, 3'h0, 16'h0000);
        for (int d = 0; d < 3; d++) begin
            rd(cmd(d[1:0]), 1'b0, 3'h2, 16'h0000);
        end
        push(3);
        check("protect lamp", 16'h0001, {15'h0, protect_lamp});
        rd(cmd(DIR_LEVEL2), 1'b0, 3'h2, 16'h0000);
        rd(cmd(DIR_LEVEL2), 1'b1, 3'h5, exp_st());
        push(3);
        rd(cmd(DIR_LEVEL2), 1'b0, 3'h5, exp_st());
        ready_station_card = 1'b0;
        strobe(feed_cycle_done);
        strobe(read_area_jam);
        strobe(post_read_jam);
        strobe(stacker_area_jam);
        amp_on = 12'hfff;
        strobe(preread_light_check);
        amp_on = 12'h000;
        strobe(preread_dark_check);
        sticky = 5'h0f;
        rd(cmd(DIR_LEVEL2), 1'b0, 3'h5, exp_st());
        amp_on = 12'h7ff;
        strobe(preread_light_check);
        sticky = 5'h1f;
        rd(cmd(DIR_LEVEL2), 1'b0, 3'h5, exp_st());
        check("alert lamps", 16'h0003, {14'h0, feed_alert_lamp, read_alert_lamp});
        push(1);
        check("single feed", 16'h0001, {15'h0, feed_card});
        sticky = 5'h11;
        rd(cmd(DIR_LEVEL2), 1'b0, 3'h5, exp_st());
        check("feed alert", 16'h0000, {15'h0, feed_alert_lamp});
        btn[0] = 1'b1;
        @(negedge clock);
        check("ready feed", 16'h0007, {13'h0, ready_lamp, feed_card, host_ops_enable});
        sticky = 5'h00;
        ready_station_card = 1'b1;
        rd(cmd(DIR_LEVEL2), 1'b0, 3'h5, exp_st());
        check("read alert", 16'h0000, {15'h0, read_alert_lamp});
        push(1);
        check("single ignored", 16'h0002, {14'h0, ready_lamp, feed_card});
        free_run_sw = 1'b1;
        n = 0;
        repeat (8) begin
            @(negedge clock);
            n += int'(feed_card);
        end
        check("detached", 16'h0002, {14'h0, host_detached, host_ops_enable});
        check("free run feeds", 16'h0001, {15'h0, n == 4});
        free_run_sw = 1'b0;
        @(negedge clock);
        btn[0] = 1'b0;
        @(negedge clock);
        check("held release", 16'h0001, {15'h0, host_ops_enable});
        btn[0] = 1'b1;
        @(negedge clock);
        card_busy = 1'b1;
        btn[0] = 1'b0;
        @(negedge clock);
        check("stopping", 16'h0002, {14'h0, ready_lamp, host_ops_enable});
        card_busy = 1'b0;
        repeat (2) @(negedge clock);
        check("stopped", 16'h0000, {15'h0, ready_lamp});
        btn[0] = 1'b1;
        push(2);
        check("eof set", 16'h0007, {13'h0, ready_lamp, deck_tail_lamp, deck_tail_status});
        hopper_empty = 1'b1;
        repeat (2) @(negedge clock);
        check("eof ready", 16'h0001, {15'h0, ready_lamp});
        push(2);
        @(negedge clock);
        check("eof clear", 16'h0000, {14'h0, ready_lamp, deck_tail_lamp});
        push(2);
        strobe(read_area_jam);
        strobe(master_clear);
        check("master clear", 16'h0000, {14'h0, feed_alert_lamp, deck_tail_lamp});
        btn[0] = 1'b0;
        summarize();
    end
endmodule : tb
